// file: design/dcache_ctrl.sv
`default_nettype none
module dcache_ctrl import dcache_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Load/store unit
	input wire lsu_req_t lsu_req,
	input wire logic lsu_stream,
	output logic lsu_busy,
	output logic lsu_rvalid,
	output logic [63:0] lsu_rdata,
	output logic lsu_done,
	output logic lsu_exc,
	// Bus interface unit
	input wire logic icache_miss_req,
	output bus_cmd_t bus_cmd,
	input wire bus_rsp_t bus_rsp,
	// Line state tracking
	output line_evt_t line_evt,
	// Instruction cache invalidation
	input wire logic supervisor,
	input wire logic pipeline_drained,
	output logic icache_flash_inv,
	output logic icache_line_inv,
	output logic [26:0] icache_inv_line,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack
);
	typedef enum logic [2:0] {S_IDLE, S_BUSREQ, S_XFER, S_RELEASE, S_MERGE} state_t;

	// ====================================================
	// Storage banks
	state_t state_q;
	lsu_req_t req_q;
	bus_op_t op_q;
	logic way_q;
	logic [1:0] beat_q;
	logic berr_q;
	logic bias_q;
	logic [6:0] idx_sel;
	logic [1:0][19:0] tag_r;
	logic [1:0] vld_r;
	logic [1:0] mod_r;
	logic [1:0][3:0][63:0] line_r;
	logic [1:0] st_we;
	logic [19:0] st_tag;
	logic st_v;
	logic st_m;
	logic [1:0] d_we;
	logic [1:0] d_dw;
	logic [63:0] d_data;
	logic [7:0] d_be;

	// Lookups use the live request in idle, the held one otherwise
	assign idx_sel = (state_q == S_IDLE) ? lsu_req.addr[11:5] : req_q.addr[11:5];

	for (genvar w = 0; w < 2; w++) begin : g_way
		dcache_way u_way (
			.clk(clk),
			.reset(reset),
			.idx(idx_sel),
			.tag(tag_r[w]),
			.vld(vld_r[w]),
			.mod(mod_r[w]),
			.line(line_r[w]),
			.st_we(st_we[w]),
			.st_tag(st_tag),
			.st_v(st_v),
			.st_m(st_m),
			.d_we(d_we[w]),
			.d_dw(d_dw),
			.d_data(d_data),
			.d_be(d_be)
		);
	end

	// ====================================================
	// Hit, victim and action decode
	logic [1:0] hit_w;
	logic hit;
	logic hway;
	logic victim;
	logic wthru;
	logic take;
	logic rd_hit;
	logic wr_hit;
	logic miss_alloc;
	logic wt_miss;
	logic go_bus;
	bus_op_t nxt_op;
	logic [63:0] hit_data;
	logic fill;
	logic last;
	logic err_any;
	logic [1:0] fill_dw;

	assign hit_w[0] = vld_r[0] && (tag_r[0] == lsu_req.addr[31:12]);
	assign hit_w[1] = vld_r[1] && (tag_r[1] == lsu_req.addr[31:12]);
	assign hit = |hit_w;
	assign hway = hit_w[1];
	assign hit_data = line_r[hway][lsu_req.addr[4:3]];
	// Exactly one empty candidate wins, otherwise the bias bit
	assign victim = (vld_r[0] ^ vld_r[1]) ? vld_r[0] : bias_q;
	assign wthru = lsu_req.wthru | lsu_req.stthru;
	assign take = (state_q == S_IDLE) && lsu_req.valid;
	assign rd_hit = take && !lsu_req.we && hit;
	assign wr_hit = take && lsu_req.we && hit;
	assign miss_alloc = take && !hit && (!lsu_req.we || !wthru);
	assign wt_miss = take && lsu_req.we && !hit && wthru;
	assign fill = (op_q == OP_READ) || (op_q == OP_RWITM);
	assign last = (op_q == OP_WRITE) || (op_q == OP_INVAL) || (beat_q == 2'(BEATS - 1));
	assign err_any = berr_q || bus_rsp.err;
	assign fill_dw = req_q.addr[4:3] + beat_q;

	// Which bus operation the taken access needs first
	always_comb begin
		go_bus = 1'b0;
		nxt_op = OP_WRITE;
		if (miss_alloc) begin
			go_bus = 1'b1;
			if (vld_r[victim] && mod_r[victim]) begin
				nxt_op = OP_COPYBACK;
			end else begin
				nxt_op = lsu_req.we ? OP_RWITM : OP_READ;
			end
		end else if (wr_hit && wthru) begin
			go_bus = 1'b1;
		end else if (wr_hit && !mod_r[hway] && lsu_req.glob) begin
			go_bus = 1'b1;
			nxt_op = OP_INVAL;
		end else if (wt_miss) begin
			go_bus = 1'b1;
		end
	end

	// ====================================================
	// Transfer sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= S_IDLE;
			op_q <= OP_READ;
			way_q <= 1'b0;
			beat_q <= 2'h0;
			berr_q <= 1'b0;
			req_q <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (go_bus) begin
						req_q <= lsu_req;
						op_q <= nxt_op;
						way_q <= miss_alloc ? victim : hway;
						state_q <= S_BUSREQ;
					end
				end
				S_BUSREQ: begin
					if (bus_cmd.req && bus_rsp.gnt) begin
						beat_q <= 2'h0;
						berr_q <= 1'b0;
						state_q <= S_XFER;
					end
				end
				S_XFER: begin
					if (bus_rsp.retry) begin
						state_q <= S_RELEASE;
					end else if (bus_rsp.ack) begin
						beat_q <= beat_q + 2'h1;
						berr_q <= err_any;
						if (op_q == OP_COPYBACK && bus_rsp.err) begin
							state_q <= S_IDLE;
						end else if (last) begin
							if (op_q == OP_COPYBACK) begin
								op_q <= req_q.we ? OP_RWITM : OP_READ;
								state_q <= S_BUSREQ;
							end else if (op_q == OP_RWITM && !err_any) begin
								state_q <= S_MERGE;
							end else begin
								state_q <= S_IDLE;
							end
						end
					end
				end
				S_RELEASE: state_q <= S_BUSREQ;
				S_MERGE: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Bias flips on every miss
	always_ff @(posedge clk) begin
		if (reset) begin
			bias_q <= 1'b0;
		end else if (take && !hit) begin
			bias_q <= ~bias_q;
		end
	end

	// ====================================================
	// Line state and data writes
	always_comb begin
		st_we = 2'b00;
		st_tag = req_q.addr[31:12];
		st_v = 1'b0;
		st_m = 1'b0;
		d_we = 2'b00;
		d_dw = req_q.addr[4:3];
		d_data = req_q.wdata;
		d_be = req_q.be;
		if (wr_hit) begin
			// Store data lands even if a write-through cycle later errors
			d_we[hway] = 1'b1;
			d_dw = lsu_req.addr[4:3];
			d_data = lsu_req.wdata;
			d_be = lsu_req.be;
			if (!wthru && !mod_r[hway]) begin
				st_we[hway] = 1'b1;
				st_tag = tag_r[hway];
				st_v = 1'b1;
				st_m = 1'b1;
			end
		end else if (state_q == S_BUSREQ && bus_rsp.gnt && bus_cmd.req && fill) begin
			st_we[way_q] = 1'b1; // Old contents are gone once the fill starts
		end else if (state_q == S_XFER && fill && bus_rsp.ack && !bus_rsp.retry) begin
			d_we[way_q] = 1'b1;
			d_dw = fill_dw;
			d_data = bus_rsp.rdata;
			d_be = BE_ALL;
			if (last) begin
				st_we[way_q] = 1'b1;
				st_v = !err_any;
				st_m = !err_any && (op_q == OP_RWITM);
			end
		end else if (state_q == S_MERGE) begin
			d_we[way_q] = 1'b1;
		end
	end

	// Every state write is echoed outward one cycle later
	always_ff @(posedge clk) begin
		if (reset) begin
			line_evt <= '0;
		end else begin
			line_evt.valid <= |st_we;
			line_evt.set <= idx_sel;
			line_evt.way <= st_we[1];
			line_evt.vld <= st_v;
			line_evt.mod <= st_m;
		end
	end

	// ====================================================
	// Bus request toward the bus interface unit
	always_comb begin
		bus_cmd.req = (state_q == S_XFER) || (state_q == S_BUSREQ && !icache_miss_req);
		bus_cmd.op = op_q;
		bus_cmd.addr = {req_q.addr[31:3], 3'h0};
		bus_cmd.wdata = req_q.wdata;
		bus_cmd.be = fill ? BE_ALL : req_q.be;
		if (op_q == OP_COPYBACK) begin
			bus_cmd.addr = {tag_r[way_q], req_q.addr[11:5], 5'h00};
			bus_cmd.wdata = line_r[way_q][beat_q];
			bus_cmd.be = BE_ALL;
		end
	end

	// ====================================================
	// Load/store unit answers
	assign lsu_busy = (state_q != S_IDLE);

	always_ff @(posedge clk) begin
		if (reset) begin
			lsu_rvalid <= 1'b0;
			lsu_rdata <= 64'h0;
			lsu_done <= 1'b0;
			lsu_exc <= 1'b0;
		end else begin
			lsu_rvalid <= 1'b0;
			lsu_done <= 1'b0;
			lsu_exc <= 1'b0;
			if (rd_hit) begin
				lsu_rvalid <= 1'b1;
				lsu_rdata <= hit_data;
			end
			if (wr_hit && !go_bus) begin
				lsu_done <= 1'b1;
			end
			if (state_q == S_XFER && bus_rsp.ack && !bus_rsp.retry) begin
				if (op_q == OP_READ && !bus_rsp.err && (beat_q == 2'h0 || lsu_stream)) begin
					lsu_rvalid <= 1'b1;
					lsu_rdata <= bus_rsp.rdata;
				end
				if (op_q == OP_COPYBACK && bus_rsp.err) begin
					lsu_exc <= 1'b1;
				end
				if (op_q == OP_READ && beat_q == 2'h0 && bus_rsp.err) begin
					lsu_exc <= 1'b1;
				end
				if (op_q == OP_RWITM && last && err_any) begin
					lsu_exc <= 1'b1;
				end
				if ((op_q == OP_WRITE || op_q == OP_INVAL) && last) begin
					lsu_done <= 1'b1;
				end
			end
			if (state_q == S_MERGE) begin
				lsu_done <= 1'b1;
			end
		end
	end

	// ====================================================
	// Instruction cache command registers
	logic wb_req;
	logic wr_cmd;
	logic [1:0] pend_q;
	logic [1:0] cnt_q;
	logic fire;

	assign wb_req = wb_cyc && wb_stb;
	// Writes act on the acknowledged edge only
	assign wr_cmd = wb_req && wb_ack && wb_we && (wb_adr == OFF_IC_CMD) && wb_sel[0];
	assign fire = (pend_q != 2'h0) && pipeline_drained && (cnt_q == 2'(INV_CLKS - 1));

	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack <= 1'b0;
			wb_dat_r <= 32'h0;
		end else begin
			wb_ack <= wb_req && !wb_ack;
			case (wb_adr)
				OFF_IC_ADDR: wb_dat_r <= {icache_inv_line, 5'h00};
				OFF_IC_CMD: wb_dat_r <= {30'h0, pend_q};
				default: wb_dat_r <= 32'h0;
			endcase
		end
	end

	// Byte merge on the full address word; bits 4..0 are never stored
	logic [31:0] inv_addr_wr;

	always_comb begin
		inv_addr_wr = {icache_inv_line, 5'h00};
		for (int b = 0; b < 4; b++) begin
			if (wb_sel[b]) begin
				inv_addr_wr[b*8 +: 8] = wb_dat_w[b*8 +: 8];
			end
		end
	end

	// Line address register, supervisor only
	always_ff @(posedge clk) begin
		if (reset) begin
			icache_inv_line <= 27'h0;
		end else if (wb_req && wb_ack && wb_we && supervisor && wb_adr == OFF_IC_ADDR) begin
			icache_inv_line <= inv_addr_wr[31:5];
		end
	end

	// Count only drained cycles: a stall in the pipe delays the action
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_q <= 2'h0;
			cnt_q <= 2'h0;
			icache_flash_inv <= 1'b0;
			icache_line_inv <= 1'b0;
		end else begin
			icache_flash_inv <= fire && (pend_q == CMD_FLASH_INV);
			icache_line_inv <= fire && (pend_q == CMD_LINE_INV);
			if (fire) begin
				pend_q <= 2'h0;
				cnt_q <= 2'h0;
			end else if (pend_q != 2'h0 && pipeline_drained) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (wr_cmd && supervisor && pend_q == 2'h0 &&
					(wb_dat_w[1:0] == CMD_FLASH_INV || wb_dat_w[1:0] == CMD_LINE_INV)) begin
				pend_q <= wb_dat_w[1:0];
				cnt_q <= 2'h0;
			end
		end
	end

	// ====================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_inv_cmd(logic [1:0] code);
		wr_cmd && supervisor && pend_q == 2'h0 && wb_dat_w[1:0] == code;
	endsequence
	sequence s_drained_two;
		pipeline_drained [*2];
	endsequence

	chk_flash_after_serial: assert property (
		s_inv_cmd(CMD_FLASH_INV) ##1 s_drained_two |=> icache_flash_inv)
		else $error("flash invalidate late");
	chk_line_after_serial: assert property (
		s_inv_cmd(CMD_LINE_INV) ##1 s_drained_two |=> icache_line_inv && !icache_flash_inv)
		else $error("line invalidate late");
	chk_read_hit_time: assert property (
		rd_hit |=> lsu_rvalid && lsu_rdata == $past(hit_data))
		else $error("read hit data not in one clock");
	chk_icache_first: assert property (
		icache_miss_req && state_q == S_BUSREQ |-> !bus_cmd.req)
		else $error("data miss took bus over icache");
	chk_state_shown: assert property (
		|st_we |=> line_evt.valid && line_evt.vld == $past(st_v))
		else $error("line state change not shown");
	chk_bias_toggle: assert property (
		take && !hit |=> bias_q != $past(bias_q))
		else $error("victim bias did not toggle");
	chk_retry_release: assert property (
		state_q == S_XFER && bus_rsp.retry |=> !bus_cmd.req ##1 state_q == S_BUSREQ)
		else $error("retry did not release bus");
	chk_copyback_first: assert property (
		miss_alloc && vld_r[victim] && mod_r[victim] |=> op_q == OP_COPYBACK)
		else $error("dirty victim not copied back first");
	chk_wt_no_alloc: assert property (
		wt_miss |=> (st_we == 2'b00) [*3])
		else $error("write-through miss allocated");
endmodule
`default_nettype wire

// file: design/dcache_pkg.sv
`default_nettype none
package dcache_pkg;
	localparam int TAG_W = 20;
	localparam int SETS = 128;
	localparam int BEATS = 4;
	localparam int INV_CLKS = 2;
	localparam logic [7:0] OFF_IC_ADDR = 8'h00;
	localparam logic [7:0] OFF_IC_CMD = 8'h04;
	localparam logic [1:0] CMD_FLASH_INV = 2'h1;
	localparam logic [1:0] CMD_LINE_INV = 2'h2;
	localparam logic [7:0] BE_ALL = 8'hff;

	typedef enum logic [2:0] {OP_READ, OP_RWITM, OP_WRITE, OP_COPYBACK, OP_INVAL} bus_op_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0] be;
		logic wthru;
		logic glob;
		logic stthru;
	} lsu_req_t;

	typedef struct packed {
		logic req;
		bus_op_t op;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0] be;
	} bus_cmd_t;

	typedef struct packed {
		logic gnt;
		logic ack;
		logic err;
		logic retry;
		logic [63:0] rdata;
	} bus_rsp_t;

	typedef struct packed {
		logic valid;
		logic [6:0] set;
		logic way;
		logic vld;
		logic mod;
	} line_evt_t;
endpackage
`default_nettype wire

// file: design/dcache_way.sv
`default_nettype none
module dcache_way import dcache_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Set select, shared by read and write
	input wire logic [6:0] idx,
	output logic [19:0] tag,
	output logic vld,
	output logic mod,
	output logic [3:0][63:0] line,
	// State write
	input wire logic st_we,
	input wire logic [19:0] st_tag,
	input wire logic st_v,
	input wire logic st_m,
	// Data write
	input wire logic d_we,
	input wire logic [1:0] d_dw,
	input wire logic [63:0] d_data,
	input wire logic [7:0] d_be
);
	// ====================================================
	// One bank: 128 lines of 4 double-words
	logic [SETS-1:0][19:0] tag_q;
	logic [SETS-1:0] vld_q;
	logic [SETS-1:0] mod_q;
	logic [SETS-1:0][3:0][63:0] data_q;

	assign tag = tag_q[idx];
	assign vld = vld_q[idx];
	assign mod = mod_q[idx];
	assign line = data_q[idx];

	// Two state bits per line; data needs no reset
	always_ff @(posedge clk) begin
		if (reset) begin
			vld_q <= '0;
			mod_q <= '0;
		end else if (st_we) begin
			vld_q[idx] <= st_v;
			mod_q[idx] <= st_m;
		end
	end

	always_ff @(posedge clk) begin
		if (st_we) begin
			tag_q[idx] <= st_tag;
		end
	end

	// Byte-lane merge so partial stores keep other bytes
	always_ff @(posedge clk) begin
		if (d_we) begin
			for (int b = 0; b < 8; b++) begin
				if (d_be[b]) begin
					data_q[idx][d_dw][b*8 +: 8] <= d_data[b*8 +: 8];
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/bus_mem_model.sv
`default_nettype none
// ==========
// Memory bus partner: grant, beats, retry, errors
module bus_mem_model import dcache_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bus toward the cache
	input wire bus_cmd_t cmd,
	output var bus_rsp_t rsp,
	// Pacing and faults
	input wire logic slow,
	input wire logic retry_en,
	input wire logic err_en,
	input wire logic [1:0] err_beat
);
	logic on_q, rt_q, st;
	bus_rsp_t nx;
	logic [1:0] k_q;
	logic [31:0] ba;
	// Fills wrap from the missed double-word, copyback starts at line base
	assign ba = {cmd.addr[31:5], k_q + (cmd.op == OP_COPYBACK ? 2'h0 : cmd.addr[4:3]), 3'h0};
	initial rsp = '0;
	// Idle data lines carry noise so stale values never look valid
	always @(posedge clk) begin
		st = slow && $urandom_range(1, 0) == 1;
		nx = '{gnt: 1'b0, ack: 1'b0, err: 1'b0, retry: 1'b0, rdata: {$urandom, $urandom}};
		if (reset) begin
			on_q <= 1'b0;
			rt_q <= 1'b0;
		end else if (!on_q) begin
			if (cmd.req === 1'b1 && !st && !(rsp.gnt | rsp.ack | rsp.retry)) begin
				nx.gnt = 1'b1;
				on_q <= 1'b1;
				k_q <= 2'h0;
			end
			if (!retry_en) rt_q <= 1'b0;
		end else if (cmd.req !== 1'b1) begin
			on_q <= 1'b0;
		end else if (retry_en && !rt_q && cmd.op inside {OP_READ, OP_RWITM}) begin
			// Another holder has the line dirty: push the fill off once
			nx.retry = 1'b1;
			rt_q <= 1'b1;
			on_q <= 1'b0;
		end else if (!st) begin
			nx.ack = 1'b1;
			nx.err = err_en && k_q == err_beat;
			nx.rdata = {ba, ~ba};
			k_q <= k_q + 2'h1;
			if (k_q == 2'h3 || cmd.op inside {OP_WRITE, OP_INVAL}) on_q <= 1'b0;
		end
		// One update of the response per edge
		rsp <= nx;
	end
endmodule
`default_nettype wire

// file: verif/dcache_ctrl_tb.sv
`default_nettype none
// ==========
// Self-checking bench for the data cache controller
module dcache_ctrl_tb import dcache_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	lsu_req_t rq = '0;
	logic icm = 1'b0, sup = 1'b0, drn = 1'b0, slow = 1'b0, rt = 1'b0, ee = 1'b0;
	logic [1:0] eb = 2'h0;
	logic strm = 1'b0;
	logic [3:0] sel = 4'h0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0, dr;
	logic busy, rv, dn, ex, fi, li, ack;
	logic [63:0] rd;
	logic [26:0] il;
	bus_cmd_t cmd;
	bus_rsp_t rsp;
	line_evt_t evt, ev;
	int err_total = 0, total_checks = 0, ncyc = 0;
	logic [63:0] q_rd[$];
	bus_op_t q_op[$];

	// 50 MHz clock
	always #10 clk = ~clk;

	dcache_ctrl i_dcache_ctrl (.clk(clk), .reset(reset), .lsu_req(rq), .lsu_stream(strm),
		.lsu_busy(busy), .lsu_rvalid(rv), .lsu_rdata(rd), .lsu_done(dn), .lsu_exc(ex),
		.icache_miss_req(icm), .bus_cmd(cmd), .bus_rsp(rsp), .line_evt(evt),
		.supervisor(sup), .pipeline_drained(drn), .icache_flash_inv(fi),
		.icache_line_inv(li), .icache_inv_line(il), .wb_cyc(cyc), .wb_stb(stb),
		.wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack));

	bus_mem_model i_bus_mem_model (.clk(clk), .reset(reset), .cmd(cmd), .rsp(rsp),
		.slow(slow), .retry_en(rt), .err_en(ee), .err_beat(eb));

	// ==========
	// Helpers
	task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Memory pattern of a double-word: its address and the inverse
	function automatic logic [63:0] pat(logic [31:0] a);
		return {a[31:3], 3'h0, ~{a[31:3], 3'h0}};
	endfunction

	function automatic logic [31:0] ad(logic [19:0] t, logic [6:0] s, logic [1:0] d);
		return {t, s, d, 3'h0};
	endfunction

	task automatic miss(logic [31:0] a);
		q_op.push_back(OP_READ);
		q_rd.push_back(pat(a));
	endtask

	task automatic idle;
		while (busy === 1'b1) @(posedge clk);
	endtask

	// Request stands until its taking edge; m is {write-through, global, store-through}
	task automatic lsu(logic [31:0] a, logic w, logic [63:0] d, logic [2:0] m, output int n);
		idle;
		@(posedge clk);
		rq <= '{valid: 1'b1, we: w, addr: a, wdata: d, be: BE_ALL, wthru: m[2], glob: m[1],
			stthru: m[0]};
		// The idle cache takes it at the first edge; holding it longer retakes it
		@(posedge clk);
		rq.valid <= 1'b0;
		n = 1;
		while ((rv | dn | ex) !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if ((rv | dn | ex) !== 1'b1) chk("lsu answer", 0, 1);
	endtask

	// Classic single cycle, held until ack is sampled
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
		int k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1) chk("wb ack", 0, 1);
		r = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask

	task automatic pulse(logic ln, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((ln ? li : fi) !== 1'b1 && n < 12);
	endtask

	// Scoreboard: oldest note is taken when a result or grant shows
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			if (q_rd.size() == 0) chk("extra rdata", 1, 0);
			else chk("rdata", rd, q_rd.pop_front());
		end
		if (rsp.gnt === 1'b1 && cmd.req === 1'b1) begin
			if (q_op.size() == 0) chk("extra bus op", 1, 0);
			else chk("bus op", cmd.op, q_op.pop_front());
		end
		if (evt.valid === 1'b1) ev = evt;
		ncyc++;
		if (ncyc == 6000) begin
			err_total++;
			report_and_stop;
		end
	end

	// ==========
	// Main sequence
	initial begin
		int n;
		logic [31:0] r, a, b;
		logic [19:0] t;
		logic [63:0] w;
		r = $urandom(32'hd1a8);
		t = 20'($urandom);
		w = {$urandom, $urandom};
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		sup <= 1'b1;
		drn <= 1'b1;
		wb(1'b1, OFF_IC_ADDR, w[31:0], r);
		wb(1'b0, OFF_IC_ADDR, 32'h0, r);
		chk("addr reg", r, {w[31:5], 5'h0});
		wb(1'b1, OFF_IC_CMD, 32'(CMD_LINE_INV), r);
		pulse(1'b1, n);
		chk("line inv delay", n, 3);
		chk("line inv addr", il, w[31:5]);
		wb(1'b1, OFF_IC_CMD, 32'(CMD_FLASH_INV), r);
		pulse(1'b0, n);
		chk("flash delay", n, 3);
		drn <= 1'b0;
		wb(1'b1, OFF_IC_CMD, 32'(CMD_FLASH_INV), r);
		pulse(1'b0, n);
		chk("flash undrained", n, 12);
		drn <= 1'b1;
		pulse(1'b0, n);
		chk("flash after drain", n < 5, 1);
		sup <= 1'b0;
		wb(1'b1, OFF_IC_CMD, 32'(CMD_FLASH_INV), r);
		pulse(1'b0, n);
		chk("user flash", n, 12);
		sup <= 1'b1;
		wb(1'b0, 8'h08, 32'h0, r);
		chk("unmapped", r, 0);
		$display("test registers done");
		// Read miss, hit, then local store hit
		a = ad(t, 7'h05, 2'h2);
		miss(a);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		chk("busy in fill", busy, 1);
		q_rd.push_back(pat(ad(t, 7'h05, 2'h0)));
		lsu(ad(t, 7'h05, 2'h0), 1'b0, 64'h0, 3'h0, n);
		chk("hit delay", n, 2);
		chk("fill state", {ev.set, ev.way, ev.vld, ev.mod}, {7'h05, 3'h2});
		lsu(a, 1'b1, w, 3'h0, n);
		chk("store hit delay", n, 2);
		q_rd.push_back(w);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		chk("dirty state", {ev.vld, ev.mod}, 2'h3);
		b = ad(t + 20'h1, 7'h05, 2'h1);
		miss(b);
		lsu(b, 1'b0, 64'h0, 3'h0, n);
		q_op.push_back(OP_INVAL);
		lsu(b, 1'b1, ~w, 3'h2, n);
		$display("test hits done");
		// Both ways dirty: evict with copyback, first fill is retried
		rt <= 1'b1;
		a = ad(t + 20'h2, 7'h05, 2'h3);
		q_op.push_back(OP_COPYBACK);
		q_op.push_back(OP_READ);
		miss(a);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		rt <= 1'b0;
		q_op.push_back(OP_WRITE);
		lsu(a, 1'b1, w, 3'h4, n);
		q_op.push_back(OP_WRITE);
		lsu(a, 1'b1, ~w, 3'h1, n);
		q_rd.push_back(~w);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		// Slow partner from here on
		slow <= 1'b1;
		a = ad(t + 20'h3, 7'h09, 2'h0);
		q_op.push_back(OP_WRITE);
		lsu(a, 1'b1, w, 3'h4, n);
		miss(a);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		a = ad(t + 20'h4, 7'h14, 2'h1);
		q_op.push_back(OP_RWITM);
		lsu(a, 1'b1, w, 3'h0, n);
		q_rd.push_back(w);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		$display("test writes done");
		// Streamed fill: every double-word reaches the unit in wrap order
		strm <= 1'b1;
		q_op.push_back(OP_READ);
		for (int i = 0; i < 4; i++)
			q_rd.push_back(pat(ad(t + 20'h8, 7'h30, 2'(i + 1))));
		lsu(ad(t + 20'h8, 7'h30, 2'h1), 1'b0, 64'h0, 3'h0, n);
		idle;
		strm <= 1'b0;
		// Error on a later beat leaves the line invalid
		ee <= 1'b1;
		eb <= 2'h2;
		a = ad(t + 20'h5, 7'h1e, 2'h2);
		miss(a);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		idle;
		ee <= 1'b0;
		miss(a);
		lsu(a, 1'b0, 64'h0, 3'h0, n);
		idle;
		eb <= 2'h0;
		ee <= 1'b1;
		q_op.push_back(OP_READ);
		lsu(ad(t + 20'h6, 7'h1f, 2'h0), 1'b0, 64'h0, 3'h0, n);
		chk("exception", ex, 1);
		idle;
		ee <= 1'b0;
		// Instruction fetch miss keeps the data request off the bus
		a = ad(t + 20'h7, 7'h28, 2'h1);
		miss(a);
		icm <= 1'b1;
		fork
			lsu(a, 1'b0, 64'h0, 3'h0, n);
			begin
				repeat (6) @(posedge clk);
				chk("req held", cmd.req, 0);
				icm <= 1'b0;
			end
		join
		$display("test faults done");
		idle;
		repeat (10) @(posedge clk);
		chk("queues empty", q_rd.size() + q_op.size(), 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
